/* shared/hsiso_pkg.sv */
// Constants, offsets and carrier types of the isochronous microframe results block.
// Assumes one 20 MHz clock, APB register access and a link engine that is synchronous to it.
//
// Notes on behaviour
// R1: Store a 12-bit received count per microframe, only if active and frame matched.
// R2: Microframe 2 count splits: low byte in word bits 63:56, high nibble bits 3:0.
// R3: Counts of microframes 3, 1, 0 sit at bits 15:4, 55:44 and 43:32.
// R4: Eight 3-bit result codes packed from 31:29 (microframe 7) to 10:8 (microframe 0).
// R5: A result code is written only after that microframe's payload went out.
// R6: Code bit 0 transaction error, bit 1 babble (IN), bit 2 underrun (OUT).
// R7: Software sets active bits, hardware clears each once its microframe is processed.
// R8: Active bits are checked only when frame-select bits match the bus frame number.
// R9: All eight active bits set means a transaction in every microframe.
// R10: Only microframes whose active bit is set get a transaction.
// R11: Software puts the frame number in select bits 7:3; bits 2:0 ignored.
// R12: The descriptor active bit acts as its valid bit; the code adds a separate CTRL valid bit that gates every request.
// R13: Skipped microframes keep their count and result code unchanged.
package hsiso_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ACTIVE = 8'h04;
  localparam logic [7:0] OFF_DW4 = 8'h08;
  localparam logic [7:0] OFF_DW5 = 8'h0c;
  localparam logic [7:0] OFF_DW6 = 8'h10;
  localparam logic [7:0] OFF_DW7 = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;

  // ==========================================================
  // Field layout
  localparam int CTRL_VALID_BIT = 0;
  localparam int CTRL_DIR_IN_BIT = 1;
  localparam int CTRL_FSEL_LSB = 8;
  localparam int FSEL_W = 8;
  localparam int FRAME_LSB = 3;
  localparam int FRAME_W = 5;
  localparam int N_UF = 8;
  localparam int UF_W = 3;
  localparam int CNT_W = 12;
  localparam int CODE_W = 3;
  localparam int CODE_LSB = 8;
  localparam int CODE_XERR_BIT = 0;
  localparam int CODE_BABBLE_BIT = 1;
  localparam int CODE_UNDERRUN_BIT = 2;
  localparam int IRQ_W = 3;
  localparam int IRQ_UF_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_ALL_DONE = 2;

  // ==========================================================
  // Reset values
  localparam logic [FSEL_W-1:0] FSEL_RST = 8'h00;
  localparam logic [N_UF-1:0] ACTIVE_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
  localparam logic [CODE_W-1:0] CODE_RST = 3'h0;

  // ==========================================================
  // Types
  typedef enum logic [0:0] {ST_IDLE, ST_WAIT} hsiso_state_t;

  // Microframe start from the bus side
  typedef struct packed {
    logic sof;
    logic [UF_W-1:0] uf;
    logic [FRAME_W-1:0] frame;
  } hsiso_sof_t;

  // Transaction request to the endpoint engine
  typedef struct packed {
    logic go;
    logic [UF_W-1:0] uf;
    logic dir_in;
  } hsiso_req_t;

  // Transaction result after payload delivery
  typedef struct packed {
    logic done;
    logic [CNT_W-1:0] count;
    logic xerr;
    logic babble;
    logic underrun;
  } hsiso_res_t;

endpackage

/* design/hsiso_uf_slot.sv */
// One microframe's stored byte count and result code.
// Assumes the write enable is a one-cycle pulse from the results engine.
`timescale 1ns/1ns
module hsiso_uf_slot #(
  parameter int CW = 12,
  parameter int SW = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [CW-1:0] count_in,
  input wire logic [SW-1:0] code_in,
  output logic [CW-1:0] count,
  output logic [SW-1:0] code
);
  logic [CW-1:0] count_ff;
  logic [SW-1:0] code_ff;
  logic [CW-1:0] nxt_count;
  logic [SW-1:0] nxt_code;

  // Hold value unless written
  always_comb begin
    nxt_count = wr_en ? count_in : count_ff;
    nxt_code = wr_en ? code_in : code_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= '0;
      code_ff <= '0;
    end else begin
      count_ff <= nxt_count;
      code_ff <= nxt_code;
    end
  end

  assign count = count_ff;
  assign code = code_ff;
endmodule

/* design/hsiso_results.sv */
// Isochronous microframe scheduler and result write-back with APB registers.
// Assumes APB master on pclk; bus-side strobes are synchronous single-cycle pulses.
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module hsiso_results (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire hsiso_pkg::hsiso_sof_t sof_in,
  input wire hsiso_pkg::hsiso_res_t res_in,
  output hsiso_pkg::hsiso_req_t req_out,
  output logic irq
);
  import hsiso_pkg::*;

  // ==========================================================
  // Declarations
  logic valid_ff, nxt_valid;
  logic dir_in_ff, nxt_dir_in;
  logic [FSEL_W-1:0] fsel_ff, nxt_fsel;
  logic [N_UF-1:0] active_ff, nxt_active;
  logic [IRQ_W-1:0] irq_stat_ff, nxt_irq_stat;
  logic [IRQ_W-1:0] irq_mask_ff, nxt_irq_mask;
  logic irq_ff, nxt_irq;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  hsiso_state_t state_ff, nxt_state;
  logic [UF_W-1:0] cur_uf_ff, nxt_cur_uf;
  hsiso_req_t req_ff, nxt_req;
  logic [N_UF-1:0] slot_we;
  logic [N_UF-1:0] uf_clear;
  logic [IRQ_W-1:0] events;
  logic [CODE_W-1:0] new_code;
  logic eligible;
  logic apb_acc;
  logic apb_wr;
  logic mapped;
  logic [CNT_W-1:0] cnt [N_UF];
  logic [CODE_W-1:0] code [N_UF];
  logic [31:0] dw4_img, dw5_img, dw6_img, dw7_img;

  // ==========================================================
  // Per-microframe result storage
  for (genvar g = 0; g < N_UF; g++) begin : g_slot
    hsiso_uf_slot #(.CW(CNT_W), .SW(CODE_W)) u_slot (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(slot_we[g]),
      .count_in(res_in.count),
      .code_in(new_code),
      .count(cnt[g]),
      .code(code[g])
    );
  end

  // ==========================================================
  // Descriptor word images
  always_comb begin
    dw4_img = {code[7], code[6], code[5], code[4], code[3], code[2], code[1], code[0], // [R4]
      active_ff};
    dw5_img = {cnt[2][7:0], cnt[1], cnt[0]}; // [R2] [R3]
    dw6_img = {cnt[5][3:0], cnt[4], cnt[3], cnt[2][11:8]}; // [R2] [R3]
    dw7_img = {cnt[7], cnt[6], cnt[5][11:4]};
  end

  // ==========================================================
  // Results engine
  // Frame match uses select bits 7:3 only; CTRL valid and microframe active bits both gate the request
  assign eligible = sof_in.sof && valid_ff // [R12]
    && (sof_in.frame == fsel_ff[FSEL_W-1:FRAME_LSB]) // [R8] [R11]
    && active_ff[sof_in.uf]; // [R9] [R10]

  always_comb begin
    nxt_state = state_ff;
    nxt_cur_uf = cur_uf_ff;
    nxt_req = '0;
    nxt_req.uf = req_ff.uf;
    nxt_req.dir_in = req_ff.dir_in;
    slot_we = '0;
    uf_clear = '0;
    events = '0;
    // Babble and underrun bits qualified by direction; transaction error taken as is
    new_code = '0;
    new_code[CODE_XERR_BIT] = res_in.xerr; // [R6]
    new_code[CODE_BABBLE_BIT] = res_in.babble && dir_in_ff; // [R6]
    new_code[CODE_UNDERRUN_BIT] = res_in.underrun && !dir_in_ff; // [R6]
    unique case (state_ff)
      ST_IDLE: begin
        // Skipped microframes touch nothing
        if (eligible) begin // [R13]
          nxt_req.go = 1'b1;
          nxt_req.uf = sof_in.uf;
          nxt_req.dir_in = dir_in_ff;
          nxt_cur_uf = sof_in.uf;
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Write back only once payload delivered
        if (res_in.done) begin // [R5]
          slot_we[cur_uf_ff] = 1'b1; // [R1]
          uf_clear[cur_uf_ff] = 1'b1; // [R7]
          events[IRQ_UF_DONE] = 1'b1;
          events[IRQ_ERR] = |new_code;
          events[IRQ_ALL_DONE] = ((active_ff & ~uf_clear) == '0);
          nxt_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      cur_uf_ff <= '0;
      req_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cur_uf_ff <= nxt_cur_uf;
      req_ff <= nxt_req;
    end
  end

  // ==========================================================
  // APB slave and registers
  assign apb_acc = psel && penable && pready_ff;
  assign apb_wr = apb_acc && pwrite;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= OFF_IRQ_MASK);

  always_comb begin
    nxt_valid = valid_ff;
    nxt_dir_in = dir_in_ff;
    nxt_fsel = fsel_ff;
    nxt_irq_mask = irq_mask_ff;
    // One wait state: ready on the second access cycle
    nxt_pready = psel && penable && !pready_ff;
    nxt_pslverr = nxt_pready && !mapped;
    nxt_prdata = prdata_ff;
    if (nxt_pready && !pwrite) begin
      unique case (paddr)
        OFF_CTRL: nxt_prdata = {16'h0000, fsel_ff, 6'h00, dir_in_ff, valid_ff};
        OFF_ACTIVE: nxt_prdata = {24'h000000, active_ff};
        OFF_DW4: nxt_prdata = dw4_img;
        OFF_DW5: nxt_prdata = dw5_img;
        OFF_DW6: nxt_prdata = dw6_img;
        OFF_DW7: nxt_prdata = dw7_img;
        OFF_IRQ_STAT: nxt_prdata = {29'h00000000, irq_stat_ff};
        OFF_IRQ_MASK: nxt_prdata = {29'h00000000, irq_mask_ff};
        default: nxt_prdata = 32'h00000000;
      endcase
    end
    // Hardware clears processed microframes, software write-one sets
    nxt_active = active_ff & ~uf_clear; // [R7]
    // Status read clears only bits that were returned; new events win
    nxt_irq_stat = irq_stat_ff;
    if (apb_acc && !pwrite && paddr == OFF_IRQ_STAT) begin
      nxt_irq_stat = irq_stat_ff & ~prdata_ff[IRQ_W-1:0];
    end
    nxt_irq_stat = nxt_irq_stat | events;
    if (apb_wr) begin
      unique case (paddr)
        OFF_CTRL: begin
          nxt_valid = pwdata[CTRL_VALID_BIT];
          nxt_dir_in = pwdata[CTRL_DIR_IN_BIT];
          nxt_fsel = pwdata[CTRL_FSEL_LSB +: FSEL_W];
        end
        OFF_ACTIVE: nxt_active = nxt_active | pwdata[N_UF-1:0]; // [R7]
        OFF_IRQ_MASK: nxt_irq_mask = pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_ff <= 1'b0;
      dir_in_ff <= 1'b0;
      fsel_ff <= FSEL_RST;
      active_ff <= ACTIVE_RST;
      irq_stat_ff <= '0;
      irq_mask_ff <= IRQ_MASK_RST;
      irq_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      valid_ff <= nxt_valid;
      dir_in_ff <= nxt_dir_in;
      fsel_ff <= nxt_fsel;
      active_ff <= nxt_active;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      irq_ff <= nxt_irq;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Outputs straight from flip-flops
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign req_out = req_ff;
  assign irq = irq_ff;

  // ==========================================================
  // Assertions
  property p_go_cause;
    @(posedge pclk) disable iff (!presetn)
    req_out.go |-> $past(sof_in.sof) && $past(valid_ff)
      && ($past(sof_in.frame) == $past(fsel_ff[7:3])) && $past(active_ff[sof_in.uf]);
  endproperty
  a_go_cause: assert property (p_go_cause) else $error("request without eligible microframe"); // [R8]

  property p_all_active;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == ST_IDLE && sof_in.sof && valid_ff && active_ff == 8'hff
      && sof_in.frame == fsel_ff[7:3]) |=> req_out.go && req_out.uf == $past(sof_in.uf);
  endproperty
  a_all_active: assert property (p_all_active) else $error("active microframe not run"); // [R9]

  property p_skip;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == ST_IDLE && sof_in.sof && !active_ff[sof_in.uf]) |=>
      !req_out.go && state_ff == ST_IDLE;
  endproperty
  a_skip: assert property (p_skip) else $error("inactive microframe was run"); // [R10]

  property p_count_store;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == ST_WAIT && res_in.done) |=> cnt[$past(cur_uf_ff)] == $past(res_in.count)
      && code[$past(cur_uf_ff)][0] == $past(res_in.xerr);
  endproperty
  a_count_store: assert property (p_count_store) else $error("count not stored"); // [R1]

  property p_write_after_done;
    @(posedge pclk) disable iff (!presetn)
    (|slot_we) |-> state_ff == ST_WAIT && res_in.done;
  endproperty
  a_write_after_done: assert property (p_write_after_done) else $error("early write"); // [R5]

  property p_dir_code;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == ST_WAIT && res_in.done) |=>
      ($past(dir_in_ff) ? !code[$past(cur_uf_ff)][2] : !code[$past(cur_uf_ff)][1]);
  endproperty
  a_dir_code: assert property (p_dir_code) else $error("code bit for wrong direction"); // [R6]

  property p_clear_active;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == ST_WAIT && res_in.done && !(apb_wr && paddr == OFF_ACTIVE)) |=>
      !active_ff[$past(cur_uf_ff)];
  endproperty
  a_clear_active: assert property (p_clear_active) else $error("active bit not cleared"); // [R7]

  property p_idle_hold;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == ST_IDLE) |=> $stable(dw5_img) && $stable(dw4_img[31:8]);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("results changed while idle"); // [R13]

  property p_dw_read;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready_ff && !pwrite && paddr == OFF_DW6) |=>
      prdata[3:0] == $past(cnt[2][11:8]) && prdata[15:4] == $past(cnt[3]);
  endproperty
  a_dw_read: assert property (p_dw_read) else $error("count layout wrong"); // [R2] [R3]

  property p_code_pos;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready_ff && !pwrite && paddr == OFF_DW4) |=>
      prdata[31:29] == $past(code[7]) && prdata[10:8] == $past(code[0]);
  endproperty
  a_code_pos: assert property (p_code_pos) else $error("code layout wrong"); // [R4]

  property p_valid_gate;
    @(posedge pclk) disable iff (!presetn)
    !valid_ff |=> !req_out.go;
  endproperty
  a_valid_gate: assert property (p_valid_gate) else $error("run while not valid"); // [R12]

  // No second request while one transaction is outstanding
  property p_busy_hold;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == ST_WAIT) |=> !req_out.go;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("request while busy"); // [R5]

  c_run: cover property (@(posedge pclk) disable iff (!presetn) req_out.go ##[1:20] res_in.done);
  c_err: cover property (@(posedge pclk) disable iff (!presetn) events[IRQ_ERR]);
  c_all: cover property (@(posedge pclk) disable iff (!presetn) events[IRQ_ALL_DONE] && irq);
endmodule

/* sim/hsiso_ep_model.sv */
// Behavioural isochronous endpoint on the far side of the results block.
// Assumes requests arrive as one-cycle go pulses on pclk, one outstanding at a time.
`timescale 1ns/1ns
module hsiso_ep_model
  import hsiso_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire hsiso_pkg::hsiso_req_t req,
  output hsiso_pkg::hsiso_res_t res
);
  // ==========================================================
  // Transaction timing
  logic busy_ff;
  logic [3:0] wait_ff;
  logic [UF_W-1:0] uf_ff;
  logic dir_ff;

  // Latch request, delay grows with microframe index
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff <= 1'b0;
      wait_ff <= 4'h0;
      uf_ff <= 3'h0;
      dir_ff <= 1'b0;
    end else if (req.go) begin
      busy_ff <= 1'b1;
      wait_ff <= {req.uf, 1'b0};
      uf_ff <= req.uf;
      dir_ff <= req.dir_in;
    end else if (busy_ff) begin
      if (wait_ff == 4'h0) busy_ff <= 1'b0;
      else wait_ff <= wait_ff - 4'h1;
    end
  end

  // Result fields only meaningful with done, junk otherwise
  always_comb begin
    res.done = busy_ff && (wait_ff == 4'h0);
    res.count = res.done ? {4'ha, uf_ff, dir_ff, 4'h5} : 12'hfff;
    res.xerr = res.done ? uf_ff[2] : 1'b1;
    res.babble = res.done ? uf_ff[0] : 1'b1;
    res.underrun = res.done ? uf_ff[1] : 1'b1;
  end
endmodule

/* sim/hsiso_results_bench.sv */
// Self-checking bench of the microframe results block over APB.
// Assumes the endpoint model answers every go; bench makes the microframe starts.
`timescale 1ns/1ns
module hsiso_results_bench;
  import hsiso_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  hsiso_sof_t sof_in = '0;
  hsiso_res_t res_in;
  hsiso_req_t req_out;
  int error_cnt = 0;
  int tests_run = 0;
  // Expected state
  logic [CNT_W-1:0] m_cnt [N_UF];
  logic [CODE_W-1:0] m_code [N_UF];
  logic [7:0] m_act = 8'h00;
  logic [2:0] m_stat = 3'h0;
  logic m_dir;
  logic [31:0] q;
  logic e;

  always #25 pclk = ~pclk;

  hsiso_results dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sof_in(sof_in), .res_in(res_in), .req_out(req_out), .irq(irq));
  hsiso_ep_model ep_u (.pclk(pclk), .presetn(presetn), .req(req_out), .res(res_in));

  // ==========================================================
  // Checking and closing
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Cut a hang short
  initial begin
    #2000000;
    error_cnt++;
    give_verdict();
  end

  // ==========================================================
  // APB master
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) chk("pready", 0, 1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, q, x);
    chk("pslverr", e, 0);
  endtask

  // ==========================================================
  // One microframe start, with expected write-back
  task automatic run_uf(input logic [2:0] uf, input logic [4:0] fr, input logic elig);
    logic seen;
    int n;
    seen = 1'b0;
    @(posedge pclk);
    sof_in <= {1'b1, uf, fr};
    for (n = 0; n < 3 && !seen; n++) begin
      @(posedge pclk);
      if (n == 0) sof_in.sof <= 1'b0;
      if (req_out.go === 1'b1) seen = 1'b1;
    end
    chk("go", seen, elig);
    if (seen) begin
      chk("req", {req_out.uf, req_out.dir_in}, {uf, m_dir});
      n = 0;
      @(posedge pclk);
      while (res_in.done !== 1'b1 && n < 30) begin
        n++;
        @(posedge pclk);
      end
      if (n == 30) chk("done", 0, 1);
      m_cnt[uf] = {4'ha, uf, m_dir, 4'h5};
      m_code[uf] = {uf[1] & ~m_dir, uf[0] & m_dir, uf[2]};
      m_act[uf] = 1'b0;
      m_stat = m_stat | {m_act == 8'h00, m_code[uf] != 3'h0, 1'b1};
    end
    repeat (2) @(posedge pclk);
  endtask

  // Compare every descriptor word image
  task automatic chk_dw();
    rd("active", OFF_ACTIVE, {24'h0, m_act});
    rd("dw4", OFF_DW4, {m_code[7], m_code[6], m_code[5], m_code[4], m_code[3],
       m_code[2], m_code[1], m_code[0], m_act});
    rd("dw5", OFF_DW5, {m_cnt[2][7:0], m_cnt[1], m_cnt[0]});
    rd("dw6", OFF_DW6, {m_cnt[5][3:0], m_cnt[4], m_cnt[3], m_cnt[2][11:8]});
    rd("dw7", OFF_DW7, {m_cnt[7], m_cnt[6], m_cnt[5][11:4]});
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    for (int i = 0; i < N_UF; i++) begin
      m_cnt[i] = CNT_RST;
      m_code[i] = CODE_RST;
    end
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and unmapped access
    for (int a = 0; a < 32; a += 4) rd("reset", a[7:0], 32'h0);
    wr(8'h22, 32'hffff_ffff);
    apb(1'b0, 8'h20, 32'h0, q, e);
    chk("unmapped err", e, 1);
    chk("unmapped data", q, 0);
    $display("Test reset done");
    // IN, alternate microframes, select low bits nonzero
    m_dir = 1'b1;
    wr(OFF_CTRL, 32'h0000_2f02);
    wr(OFF_ACTIVE, 32'h55);
    m_act = 8'h55;
    wr(OFF_IRQ_MASK, 32'h7);
    run_uf(3'd0, 5'd5, 1'b0);
    wr(OFF_CTRL, 32'h0000_2f03);
    run_uf(3'd0, 5'd6, 1'b0);
    chk_dw();
    for (int u = 0; u < 8; u++) run_uf(u[2:0], 5'd5, u[0] == 1'b0);
    chk_dw();
    chk("irq on", irq, 1);
    rd("stat", OFF_IRQ_STAT, {29'h0, m_stat});
    m_stat = 3'h0;
    rd("stat clr", OFF_IRQ_STAT, 32'h0);
    chk("irq off", irq, 0);
    $display("Test alternate done");
    // OUT, every microframe, events masked off
    m_dir = 1'b0;
    wr(OFF_CTRL, 32'h0000_2801);
    wr(OFF_IRQ_MASK, 32'h0);
    wr(OFF_ACTIVE, 32'hff);
    m_act = 8'hff;
    for (int u = 0; u < 8; u++) run_uf(u[2:0], 5'd5, 1'b1);
    run_uf(3'd1, 5'd5, 1'b0);
    chk_dw();
    chk("irq masked", irq, 0);
    rd("stat", OFF_IRQ_STAT, {29'h0, m_stat});
    $display("Test full frame done");
    give_verdict();
  end
endmodule
